// [hdl/cpurs_pkg.sv]
// Overview of operation
// RULE_01: Flat 64 Kbyte space, I/O, data, program.
// RULE_02: Instruction pointer is a 16-bit register.
// RULE_03: Accumulator 16 bits, byte ops use low.
// RULE_04: Temporary operand 16 bits, byte ops low.
// RULE_05: Index, extra and stack pointers, 16 bits.
// RULE_06: Status word: pointers high, flags low byte.
// RULE_07: Direct addresses 0000-007F are never remapped.
// RULE_08: Direct 0080-00FF remapped by page pointer.
// RULE_09: Half carry from bit 3 to bit 4.
// RULE_10: Interrupt enable gates; reset clears it.
// RULE_11: Level field gates lower priority requests.
// RULE_12: Negative flag copies result MSB.
// RULE_13: Zero flag set on zero result.
// RULE_14: Overflow flag on two's complement overflow.
// RULE_15: Carry out of bit 7; shifts load shifted bit.
// RULE_16: Eight byte registers per bank, 32 banks.
// RULE_17: Bank pointer and opcode low bits select.
// RULE_18: Register address is 0100 plus 8*bank+index.
package cpurs_pkg;
  // Bus register byte offsets
  localparam logic [7:0] OFF_IP = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_TMP = 8'h08;
  localparam logic [7:0] OFF_IX = 8'h0C;
  localparam logic [7:0] OFF_EP = 8'h10;
  localparam logic [7:0] OFF_SP = 8'h14;
  localparam logic [7:0] OFF_PSW = 8'h18;
  localparam logic [7:0] OFF_ALU = 8'h1C;
  localparam logic [7:0] OFF_DIR = 8'h20;
  localparam logic [7:0] OFF_GPR = 8'h24;
  localparam logic [7:0] OFF_IRQ = 8'h28;
  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] PSW_RST = 16'h0030;
  localparam logic [2:0] GPR_IDX_RST = 3'h0;
  localparam logic [1:0] IRQ_LVL_RST = 2'h3;
  // Memory space layout
  localparam logic [15:0] IO_TOP = 16'h007F;
  localparam logic [15:0] DIR_TOP = 16'h00FF;
  localparam logic [15:0] PROG_BASE = 16'h8000;
  localparam logic [7:0] GPR_BASE_HI = 8'h01;
  // Response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR} cpurs_alu_e;
  typedef enum logic [1:0] {REG_IO, REG_DATA, REG_PROG} cpurs_region_e;

  // Status word layout
  typedef struct packed { // RULE_06
    logic [4:0] rp;
    logic [2:0] dp;
    logic h;
    logic i;
    logic [1:0] il;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpurs_psw_s;

  // Byte result with its flags
  typedef struct packed {
    logic [7:0] res;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpurs_alu_s;
endpackage : cpurs_pkg

// [hdl/cpurs_core_regs.sv]
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpurs_core_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core state
  output logic [15:0] instruction_pointer,
  output cpurs_pkg::cpurs_psw_s program_status_word
);

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Direct address remap through the page pointer
  function automatic logic [15:0] dir_map(input logic [15:0] a,
      input logic [2:0] dp);
    if (a <= cpurs_pkg::IO_TOP || a > cpurs_pkg::DIR_TOP ||
        dp == 3'h0) begin // RULE_07
      dir_map = a;
    end else begin
      dir_map = {5'h00, {1'b0, dp} + 4'h1, a[6:0]}; // RULE_08
    end
  endfunction : dir_map

  // Region of the 64 Kbyte space
  function automatic cpurs_pkg::cpurs_region_e region(input logic [15:0] a);
    if (a <= cpurs_pkg::IO_TOP) begin // RULE_01
      region = cpurs_pkg::REG_IO;
    end else if (a < cpurs_pkg::PROG_BASE) begin
      region = cpurs_pkg::REG_DATA;
    end else begin
      region = cpurs_pkg::REG_PROG;
    end
  endfunction : region

  // Byte arithmetic and shifts with flags
  function automatic cpurs_pkg::cpurs_alu_s alu8(
      input cpurs_pkg::cpurs_alu_e op, input logic [7:0] a,
      input logic [7:0] b, input cpurs_pkg::cpurs_psw_s p);
    cpurs_pkg::cpurs_alu_s r;
    logic [8:0] s;
    logic [4:0] hs;
    r = '0;
    r.h = p.h;
    r.v = p.v;
    r.c = p.c;
    hs = 5'h00;
    case (op)
      cpurs_pkg::ALU_ADD: begin
        s = {1'b0, a} + {1'b0, b};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        r.h = hs[4]; // RULE_09
        r.c = s[8]; // RULE_15
        r.v = (a[7] == b[7]) && (s[7] != a[7]); // RULE_14
      end
      cpurs_pkg::ALU_SUB: begin
        s = {1'b0, a} - {1'b0, b};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        r.h = hs[4]; // RULE_09
        r.c = s[8]; // RULE_15
        r.v = (a[7] != b[7]) && (s[7] != a[7]); // RULE_14
      end
      cpurs_pkg::ALU_SHL: begin
        s = {a, 1'b0};
        r.c = a[7]; // RULE_15
      end
      default: begin
        s = {2'b00, a[7:1]};
        r.c = a[0]; // RULE_15
      end
    endcase
    r.res = s[7:0];
    r.n = s[7]; // RULE_12
    r.z = (s[7:0] == 8'h00); // RULE_13
    alu8 = r;
  endfunction : alu8

  logic [15:0] ip_q;
  logic [15:0] acc_q;
  logic [15:0] tmp_q;
  logic [15:0] ix_q;
  logic [15:0] ep_q;
  logic [15:0] sp_q;
  cpurs_pkg::cpurs_psw_s psw_q;
  logic [15:0] dir_addr_q;
  logic [2:0] gpr_idx_q;
  logic [1:0] req_lvl_q;
  logic irq_ok_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic ar_go;
  logic wr_hit;
  logic alu_go;
  logic [15:0] dir_mapped;
  logic [15:0] gpr_addr;
  logic [31:0] rdata_d;
  logic rd_hit;
  cpurs_pkg::cpurs_alu_s alu_r;

  // Write handshake: address and data taken together
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign ar_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign alu_go = wr_go && s_axi_awaddr == cpurs_pkg::OFF_ALU &&
                  s_axi_wstrb[0];
  assign alu_r = alu8(cpurs_pkg::cpurs_alu_e'(s_axi_wdata[1:0]),
                      acc_q[7:0], tmp_q[7:0], psw_q); // RULE_04

  // Remap and register bank address
  assign dir_mapped = dir_map(dir_addr_q, psw_q.dp);
  assign gpr_addr = {cpurs_pkg::GPR_BASE_HI, psw_q.rp,
                     gpr_idx_q}; // RULE_18 RULE_17 RULE_16

  // Address decode for writes
  always_comb begin
    case (s_axi_awaddr)
      cpurs_pkg::OFF_IP, cpurs_pkg::OFF_ACC, cpurs_pkg::OFF_TMP,
      cpurs_pkg::OFF_IX, cpurs_pkg::OFF_EP, cpurs_pkg::OFF_SP,
      cpurs_pkg::OFF_PSW, cpurs_pkg::OFF_ALU, cpurs_pkg::OFF_DIR,
      cpurs_pkg::OFF_GPR, cpurs_pkg::OFF_IRQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Instruction pointer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ip_q <= cpurs_pkg::WORD_RST;
    end else if (wr_go && s_axi_awaddr == cpurs_pkg::OFF_IP) begin
      ip_q <= merge16(ip_q, s_axi_wdata, s_axi_wstrb); // RULE_02
    end
  end

  // Accumulator, low byte takes byte results
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= cpurs_pkg::WORD_RST;
    end else if (alu_go) begin
      acc_q[7:0] <= alu_r.res; // RULE_03
    end else if (wr_go && s_axi_awaddr == cpurs_pkg::OFF_ACC) begin
      acc_q <= merge16(acc_q, s_axi_wdata, s_axi_wstrb);
    end
  end

  // Temporary operand
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tmp_q <= cpurs_pkg::WORD_RST;
    end else if (wr_go && s_axi_awaddr == cpurs_pkg::OFF_TMP) begin
      tmp_q <= merge16(tmp_q, s_axi_wdata, s_axi_wstrb); // RULE_04
    end
  end

  // Index, extra and stack pointers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ix_q <= cpurs_pkg::WORD_RST;
      ep_q <= cpurs_pkg::WORD_RST;
      sp_q <= cpurs_pkg::WORD_RST;
    end else if (wr_go) begin
      if (s_axi_awaddr == cpurs_pkg::OFF_IX) begin
        ix_q <= merge16(ix_q, s_axi_wdata, s_axi_wstrb); // RULE_05
      end
      if (s_axi_awaddr == cpurs_pkg::OFF_EP) begin
        ep_q <= merge16(ep_q, s_axi_wdata, s_axi_wstrb); // RULE_05
      end
      if (s_axi_awaddr == cpurs_pkg::OFF_SP) begin
        sp_q <= merge16(sp_q, s_axi_wdata, s_axi_wstrb); // RULE_05
      end
    end
  end

  // Status word: direct writes and flag updates
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      psw_q <= cpurs_pkg::PSW_RST; // RULE_10
    end else if (alu_go) begin
      psw_q.h <= alu_r.h; // RULE_09
      psw_q.n <= alu_r.n; // RULE_12
      psw_q.z <= alu_r.z; // RULE_13
      psw_q.v <= alu_r.v; // RULE_14
      psw_q.c <= alu_r.c; // RULE_15
    end else if (wr_go && s_axi_awaddr == cpurs_pkg::OFF_PSW) begin
      psw_q <= merge16(psw_q, s_axi_wdata, s_axi_wstrb); // RULE_06
    end
  end

  // Direct address, register index and request level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_addr_q <= cpurs_pkg::WORD_RST;
      gpr_idx_q <= cpurs_pkg::GPR_IDX_RST;
      req_lvl_q <= cpurs_pkg::IRQ_LVL_RST;
    end else if (wr_go) begin
      if (s_axi_awaddr == cpurs_pkg::OFF_DIR) begin
        dir_addr_q <= merge16(dir_addr_q, s_axi_wdata, s_axi_wstrb);
      end
      if (s_axi_awaddr == cpurs_pkg::OFF_GPR && s_axi_wstrb[0]) begin
        gpr_idx_q <= s_axi_wdata[2:0]; // RULE_17
      end
      if (s_axi_awaddr == cpurs_pkg::OFF_IRQ && s_axi_wstrb[0]) begin
        req_lvl_q <= s_axi_wdata[1:0];
      end
    end
  end

  // Interrupt acceptance by enable and level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ok_q <= 1'b0;
    end else begin
      irq_ok_q <= psw_q.i && (req_lvl_q < psw_q.il); // RULE_10 RULE_11
    end
  end

  // Write response
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= cpurs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? cpurs_pkg::RESP_OKAY : cpurs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data select
  always_comb begin
    rd_hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (s_axi_araddr)
      cpurs_pkg::OFF_IP: rdata_d[15:0] = ip_q;
      cpurs_pkg::OFF_ACC: rdata_d[15:0] = acc_q;
      cpurs_pkg::OFF_TMP: rdata_d[15:0] = tmp_q;
      cpurs_pkg::OFF_IX: rdata_d[15:0] = ix_q;
      cpurs_pkg::OFF_EP: rdata_d[15:0] = ep_q;
      cpurs_pkg::OFF_SP: rdata_d[15:0] = sp_q;
      cpurs_pkg::OFF_PSW: rdata_d[15:0] = psw_q;
      cpurs_pkg::OFF_ALU: rdata_d[15:0] = acc_q;
      cpurs_pkg::OFF_DIR: rdata_d[17:0] = {region(dir_mapped), dir_mapped};
      cpurs_pkg::OFF_GPR: rdata_d[15:0] = gpr_addr;
      cpurs_pkg::OFF_IRQ: rdata_d[2:0] = {irq_ok_q, req_lvl_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= cpurs_pkg::RESP_OKAY;
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rd_hit ? cpurs_pkg::RESP_OKAY : cpurs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign instruction_pointer = ip_q;
  assign program_status_word = psw_q;

  // Checks
  sequence s_alu_op(logic [1:0] op);
    alu_go && s_axi_wdata[1:0] == op;
  endsequence

  a_ip_write_load: assert property (@(posedge core_clk) // RULE_02
    disable iff (!reset_n)
    wr_go && s_axi_awaddr == cpurs_pkg::OFF_IP &&
    s_axi_wstrb[1:0] == 2'h3
    |=> ip_q == $past(s_axi_wdata[15:0]))
    else $error("ip not loaded");
  a_acc_high_kept: assert property (@(posedge core_clk) // RULE_03
    disable iff (!reset_n)
    alu_go |=> acc_q[15:8] == $past(acc_q[15:8]))
    else $error("acc high byte changed");
  a_zero_flag_set: assert property (@(posedge core_clk) // RULE_13
    disable iff (!reset_n)
    alu_go |=> psw_q.z == (acc_q[7:0] == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag_msb: assert property (@(posedge core_clk) // RULE_12
    disable iff (!reset_n)
    alu_go |=> psw_q.n == acc_q[7])
    else $error("negative flag wrong");
  a_shift_carry_out: assert property (@(posedge core_clk) // RULE_15
    disable iff (!reset_n)
    s_alu_op(2'h2) |=> psw_q.c == $past(acc_q[7]) &&
      acc_q[7:0] == {$past(acc_q[6:0]), 1'b0})
    else $error("shift carry wrong");
  a_add_half_carry: assert property (@(posedge core_clk) // RULE_09
    disable iff (!reset_n)
    s_alu_op(2'h0) |=> psw_q.h ==
      ((5'({1'b0, $past(acc_q[3:0])}) + 5'({1'b0, $past(tmp_q[3:0])})) >
      5'h0F))
    else $error("half carry wrong");
  a_dir_low_fixed: assert property (@(posedge core_clk) // RULE_07
    disable iff (!reset_n)
    dir_addr_q <= cpurs_pkg::IO_TOP |-> dir_mapped == dir_addr_q)
    else $error("low direct area remapped");
  a_dir_page_map: assert property (@(posedge core_clk) // RULE_08
    disable iff (!reset_n)
    dir_addr_q > cpurs_pkg::IO_TOP && dir_addr_q <= cpurs_pkg::DIR_TOP &&
    psw_q.dp != 3'h0 |->
      dir_mapped == 16'(16'h0080 + 16'(psw_q.dp) * 16'h0080 +
      16'(dir_addr_q[6:0])))
    else $error("direct page map wrong");
  a_gpr_bank_addr: assert property (@(posedge core_clk) // RULE_18
    disable iff (!reset_n)
    1'b1 |-> gpr_addr == 16'(16'h0100 + 16'(psw_q.rp) * 16'h0008 +
      16'(gpr_idx_q)))
    else $error("register address wrong");
  a_irq_gate_off: assert property (@(posedge core_clk) // RULE_10
    disable iff (!reset_n)
    !psw_q.i ##1 1'b1 |-> !irq_ok_q)
    else $error("irq accepted while disabled");
  a_irq_level_cmp: assert property (@(posedge core_clk) // RULE_11
    disable iff (!reset_n)
    psw_q.i && req_lvl_q >= psw_q.il |=> !irq_ok_q)
    else $error("irq level not gated");
  a_bresp_held: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule : cpurs_core_regs

// [testbench/cpurs_core_regs_tb_top.sv]
`timescale 1ns/1ps
module cpurs_core_regs_tb_top;
  // Clock, reset and bus lines
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awa = 8'h00;
  logic awv = 1'b0;
  logic awr;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'h0;
  logic wv = 1'b0;
  logic wrdy;
  logic [1:0] br;
  logic bv;
  logic bq = 1'b0;
  logic [7:0] ara = 8'h00;
  logic arv = 1'b0;
  logic arr;
  logic [31:0] rdat;
  logic [1:0] rr;
  logic rv;
  logic rq = 1'b0;
  logic [15:0] ip;
  cpurs_pkg::cpurs_psw_s psw;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] got;
  logic [1:0] resp;

  // 10 MHz clock
  always #50 clk = ~clk;

  // Device under test
  cpurs_core_regs i_dut (
    .core_clk(clk), .reset_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rq),
    .instruction_pointer(ip), .program_status_word(psw)
  );

  // Verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // One comparison
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // Handshake that never completed
  task automatic stuck(input int n);
    if (n >= 40) begin
      $display("FAIL handshake expected done seen stuck");
      bad_count++;
    end
  endtask : stuck

  // Write: address and data together, then response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    int n;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(awr === 1'b1 && wrdy === 1'b1) && n < 40);
    awv <= 1'b0;
    wv <= 1'b0;
    bq <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (bv !== 1'b1 && n < 40);
    resp = br;
    bq <= 1'b0;
    stuck(n);
  endtask : axi_wr

  // Read: address, then data and response
  task automatic axi_rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (arr !== 1'b1 && n < 40);
    arv <= 1'b0;
    rq <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rv !== 1'b1 && n < 40);
    got = rdat;
    resp = rr;
    rq <= 1'b0;
    stuck(n);
  endtask : axi_rd

  // Full word write expecting OKAY
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'h3);
    chk("bresp", 32'h0000_0000, {30'h0, resp});
  endtask : wr

  // Read and compare
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    axi_rd(a);
    chk("rresp", 32'h0000_0000, {30'h0, resp});
    chk(nm, e, got);
  endtask : rc

  // Byte operation with preset flags, then result and flags
  task automatic alu(input logic [1:0] op,
                     input logic [7:0] a, b, pre, res, fl);
    wr(8'h18, {24'h0, pre});
    wr(8'h04, {16'h0, 8'h12, a});
    wr(8'h08, {16'h0, 8'h34, b});
    wr(8'h1C, {30'h0, op});
    rc("alu_acc", 8'h1C, {16'h0, 8'h12, res});
    rc("alu_flags", 8'h18, {24'h0, fl});
  endtask : alu

  // Interrupt gating for one enable, level field and request
  task automatic irq(input logic i, input logic [1:0] il,
                     input logic [1:0] lvl, input logic ok);
    wr(8'h18, {24'h0, 1'b0, i, il, 4'h0});
    wr(8'h28, {30'h0, lvl});
    repeat (2) @(posedge clk);
    rc("irq", 8'h28, {29'h0, ok, lvl});
  endtask : irq

  // Watchdog against a hung handshake
  initial begin
    #(5000 * 100);
    bad_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    int k;
    int r;
    logic [15:0] v;
    logic [15:0] m;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("ip_port", 32'h0, {16'h0, ip});
    rc("psw", 8'h18, 32'h0000_0030);
    for (k = 0; k < 6; k++) begin
      v = 16'hF00F ^ 16'(k * 16'h0111);
      wr(8'(4 * k), {16'hFFFF, v});
      rc("word_reg", 8'(4 * k), {16'h0, v});
    end
    chk("ip_port", 32'h0000_F00F, {16'h0, ip});
    // Byte strobes on the index register
    axi_wr(8'h0C, 32'h0000_FFAB, 4'h1);
    rc("ix_low", 8'h0C, 32'h0000_F3AB);
    axi_wr(8'h0C, 32'h0000_CDFF, 4'h2);
    rc("ix_high", 8'h0C, 32'h0000_CDAB);
    // Status word split
    wr(8'h18, 32'h0000_A5C3);
    chk("psw_rp", 32'h14, {27'h0, psw.rp});
    chk("psw_dp", 32'h5, {29'h0, psw.dp});
    chk("psw_flags", 32'hC3, {24'h0, psw[7:0]});
    // Direct page mapping for every pointer value
    for (k = 0; k < 8; k++) begin
      wr(8'h18, {21'h0, 3'(k), 8'h00});
      m = (k == 0) ? 16'h0080 : 16'(16'h0100 + (k - 1) * 16'h0080);
      wr(8'h20, 32'h0000_007F);
      rc("dir_io", 8'h20, 32'h0000_007F);
      wr(8'h20, 32'h0000_0080);
      rc("dir_lo", 8'h20, {14'h0, 2'h1, m});
      wr(8'h20, 32'h0000_00FF);
      rc("dir_hi", 8'h20, {14'h0, 2'h1, m + 16'h007F});
    end
    wr(8'h20, 32'h0000_7FFF);
    rc("region_data", 8'h20, 32'h0001_7FFF);
    wr(8'h20, 32'h0000_8000);
    rc("region_prog", 8'h20, 32'h0002_8000);
    // Flags from add, subtract and shifts
    alu(2'h0, 8'h08, 8'h08, 8'h00, 8'h10, 8'h80);
    alu(2'h0, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h8A);
    alu(2'h0, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h85);
    alu(2'h1, 8'h10, 8'h01, 8'h00, 8'h0F, 8'h80);
    alu(2'h1, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h89);
    alu(2'h1, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h82);
    alu(2'h2, 8'h81, 8'h55, 8'h82, 8'h02, 8'h83);
    alu(2'h3, 8'h01, 8'h55, 8'h82, 8'h00, 8'h87);
    alu(2'h3, 8'h02, 8'h55, 8'h8F, 8'h01, 8'h82);
    // Register bank addressing, first and last bank and index
    for (k = 0; k < 6; k++) begin
      r = (k / 2 == 2) ? 31 : k / 2;
      wr(8'h18, {16'h0, 5'(r), 11'h0});
      wr(8'h24, 32'((k % 2) * 7));
      rc("gpr", 8'h24, 32'(256 + 8 * r + (k % 2) * 7));
    end
    // Interrupt enable and level gating
    irq(1'b0, 2'h3, 2'h0, 1'b0);
    irq(1'b1, 2'h3, 2'h2, 1'b1);
    irq(1'b1, 2'h3, 2'h3, 1'b0);
    irq(1'b1, 2'h1, 2'h1, 1'b0);
    irq(1'b1, 2'h1, 2'h0, 1'b1);
    irq(1'b1, 2'h0, 2'h0, 1'b0);
    // Unmapped and misaligned places
    axi_rd(8'h2C);
    chk("rresp_bad", 32'h2, {30'h0, resp});
    chk("rdata_bad", 32'h0, got);
    axi_rd(8'h02);
    chk("rresp_odd", 32'h2, {30'h0, resp});
    axi_wr(8'h30, 32'h0000_1111, 4'hF);
    chk("bresp_bad", 32'h2, {30'h0, resp});
    rc("ip_kept", 8'h00, 32'h0000_F00F);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ip_port", 32'h0, {16'h0, ip});
    chk("psw_port", 32'h0030, {16'h0, psw});
    rst_n <= 1'b1;
    @(posedge clk);
    rc("ip", 8'h00, 32'h0);
    wrap_up();
  end
endmodule : cpurs_core_regs_tb_top
